// >>> logic/frtf_pkg.sv
package frtf_pkg;

  // Register byte offsets on the APB.
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h08;
  localparam logic [7:0] ADDR_COUNTER = 8'h0c;
  localparam logic [7:0] ADDR_COMPARE_A = 8'h10;
  localparam logic [7:0] ADDR_COMPARE_B = 8'h14;
  localparam logic [7:0] ADDR_CAPTURE_A = 8'h18;
  localparam logic [7:0] ADDR_CAPTURE_B = 8'h1c;
  localparam logic [7:0] ADDR_CAPTURE_C = 8'h20;
  localparam logic [7:0] ADDR_CAPTURE_D = 8'h24;
  localparam logic [7:0] ADDR_POWER = 8'h28;

  // Status and control bit positions.
  localparam int ST_CAP_A = 7;
  localparam int ST_CAP_D = 4;
  localparam int ST_CMP_A = 3;
  localparam int ST_CMP_B = 2;
  localparam int ST_OVF = 1;
  localparam int ST_CLR_A = 0;
  localparam int CT_EDGE_A = 7;
  localparam int CT_BUF_A = 3;
  localparam int CT_BUF_B = 2;
  localparam int CT_CKS_LO = 0;

  // Reset values, the flag mask and the counter maximum.
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] IRQ_EN_RST = 8'h01;
  localparam logic [7:0] FLAG_MASK = 8'hfe;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COMPARE_RST = 16'hffff;

  // Prescaler tap encodings and divide counts.
  localparam logic [1:0] CKS_DIV2 = 2'h0;
  localparam logic [1:0] CKS_DIV8 = 2'h1;
  localparam logic [1:0] CKS_DIV32 = 2'h2;
  localparam logic [1:0] CKS_EXT = 2'h3;
  localparam int PRESCALE_W = 5;

  // Capture input pins grouped together.
  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } frtf_cap_pins_t;

  // One APB request.
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } frtf_apb_req_t;

endpackage

// >>> logic/frtf_edge_det.sv
`timescale 1ns/1ps
// Detects the selected edge on one input; the pins are treated as synchronous.
module frtf_edge_det (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  input wire logic rising_sel,
  output logic hit
);
  logic prev_r;

  // Previous level resets high-safe to zero; the first cycle may see a false edge only
  // if the pin starts high, which software tolerates by clearing the flag afterwards.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= pin;
    end
  end

  // A level of 1 picks the rising edge, 0 the falling edge.
  assign hit = rising_sel ? (pin & ~prev_r) : (~pin & prev_r);
endmodule

// >>> logic/frtf_prescaler.sv
`timescale 1ns/1ps
// Produces one increment pulse per selected source period.
module frtf_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] clk_sel,
  input wire logic ext_clk,
  output logic tick
);
  logic [frtf_pkg::PRESCALE_W-1:0] div_r;
  logic ext_prev_r;

  // Free divider; the taps give divide by 2, 8 and 32.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  // The external clock counts on its rising edge only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_clk;
    end
  end

  // Tap select, one pulse per source period.
  always_comb begin
    unique case (clk_sel)
      frtf_pkg::CKS_DIV2: tick = &div_r[0:0];
      frtf_pkg::CKS_DIV8: tick = &div_r[2:0];
      frtf_pkg::CKS_DIV32: tick = &div_r[4:0];
      frtf_pkg::CKS_EXT: tick = ext_clk & ~ext_prev_r;
    endcase
  end
endmodule

// >>> logic/frtf_timer.sv
`timescale 1ns/1ps
// Functional notes
// - Edge on input D copies the counter into capture D, sets flag bit 4.
// - Buffer mode B still sets flag D though capture D is not loaded.
// - In buffer mode B, flag D with its enable is an edge interrupt.
// - A flag clears only on a 0 write after reading it as 1, or on low-power entry.
// - Flags are set by hardware only; writing 1 leaves them unchanged.
// - Compare flag A at bit 3 sets when counter equals compare A.
// - Compare flag B at bit 2 sets when counter equals compare B.
// - Overflow flag at bit 1 sets when counter wraps from max to zero.
// - Clear-on-match-A bit 0 set makes match A reset the counter.
// - Control register returns to zero on reset and low-power entry.
// - Edge selects A to D in bits 7..4; 0 falling, 1 rising.
// - Buffer A moves old capture A into capture C before loading A.
// - Buffer B moves old capture B into capture D before loading B.
// - Control register is eight bits, fully readable and writable.
// - Clock select: div 2, div 8, div 32, external rising edge.
// - A flag raises the interrupt only while its enable bit is 1.
// - After reset the counter starts at zero and counts up.
module frtf_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire frtf_pkg::frtf_cap_pins_t cap_pins,
  input wire logic ext_clk,
  output logic irq
);
  logic [7:0] timer_control_r;
  logic [7:0] status_r;
  logic [7:0] irq_en_r;
  logic [7:0] read_seen_r;
  logic [15:0] free_running_counter_r;
  logic [15:0] compare_reg_a_r;
  logic [15:0] compare_reg_b_r;
  logic [15:0] capture_reg_a_r;
  logic [15:0] capture_reg_b_r;
  logic [15:0] capture_reg_c_r;
  logic [15:0] capture_reg_d_r;
  logic [31:0] prdata_nxt;
  logic [3:0] cap_hit;
  logic [3:0] cap_pin_vec;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic tick;
  logic match_a;
  logic match_b;
  logic wrap;
  logic wr_acc;
  logic rd_acc;
  logic low_power;
  logic addr_ok;

  // Capture pins in bit order a..d to match edge select bits 7..4.
  assign cap_pin_vec = {cap_pins.a, cap_pins.b, cap_pins.c, cap_pins.d};
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;

  // Low-power entry is a software write of 1 to the power register; it stands in
  // for standby, watch, subsleep and subactive entry of the host system.
  assign low_power = wr_acc & (paddr == frtf_pkg::ADDR_POWER) & pwdata[0];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cap
      frtf_edge_det u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .pin(cap_pin_vec[gi]),
        .rising_sel(timer_control_r[gi + 4]),
        .hit(cap_hit[gi])
      );
    end
  endgenerate

  frtf_prescaler u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .clk_sel(timer_control_r[frtf_pkg::CT_CKS_LO +: 2]),
    .ext_clk(ext_clk),
    .tick(tick)
  );

  // Match is a level while the counter sits on the value, so the flag re-sets
  // each cycle of the match; software clears after the counter moves on.
  assign match_a = (free_running_counter_r == compare_reg_a_r);
  assign match_b = (free_running_counter_r == compare_reg_b_r);
  assign wrap = tick & (free_running_counter_r == frtf_pkg::COUNT_MAX);

  // Counter starts at zero and counts on each selected increment.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      free_running_counter_r <= frtf_pkg::COUNT_RST;
    end else if (low_power) begin
      free_running_counter_r <= frtf_pkg::COUNT_RST;
    end else if (wr_acc && paddr == frtf_pkg::ADDR_COUNTER) begin
      free_running_counter_r <= pwdata[15:0];
    end else if (match_a && status_r[frtf_pkg::ST_CLR_A]) begin
      free_running_counter_r <= frtf_pkg::COUNT_RST;
    end else if (tick) begin
      free_running_counter_r <= free_running_counter_r + 16'h0001;
    end
  end

  // Control register, cleared on reset and on low-power entry.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control_r <= frtf_pkg::CONTROL_RST;
    end else if (low_power) begin
      timer_control_r <= frtf_pkg::CONTROL_RST;
    end else if (wr_acc && paddr == frtf_pkg::ADDR_CONTROL) begin
      timer_control_r <= pwdata[7:0];
    end
  end

  // Interrupt enable; bit 0 is reserved and always reads as 1.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r <= frtf_pkg::IRQ_EN_RST;
    end else if (low_power) begin
      irq_en_r <= frtf_pkg::IRQ_EN_RST;
    end else if (wr_acc && paddr == frtf_pkg::ADDR_IRQ_EN) begin
      irq_en_r <= pwdata[7:0] | frtf_pkg::IRQ_EN_RST;
    end
  end

  // Compare registers, reset to the top value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_reg_a_r <= frtf_pkg::COMPARE_RST;
      compare_reg_b_r <= frtf_pkg::COMPARE_RST;
    end else if (wr_acc && paddr == frtf_pkg::ADDR_COMPARE_A) begin
      compare_reg_a_r <= pwdata[15:0];
    end else if (wr_acc && paddr == frtf_pkg::ADDR_COMPARE_B) begin
      compare_reg_b_r <= pwdata[15:0];
    end
  end

  // Capture A and C chain.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_reg_a_r <= frtf_pkg::COUNT_RST;
      capture_reg_c_r <= frtf_pkg::COUNT_RST;
    end else if (low_power) begin
      capture_reg_a_r <= frtf_pkg::COUNT_RST;
      capture_reg_c_r <= frtf_pkg::COUNT_RST;
    end else begin
      if (cap_hit[3]) begin
        capture_reg_a_r <= free_running_counter_r;
        if (timer_control_r[frtf_pkg::CT_BUF_A]) begin
          capture_reg_c_r <= capture_reg_a_r;
        end
      end
      if (cap_hit[1] && !timer_control_r[frtf_pkg::CT_BUF_A]) begin
        capture_reg_c_r <= free_running_counter_r;
      end
    end
  end

  // Capture B and D chain.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_reg_b_r <= frtf_pkg::COUNT_RST;
      capture_reg_d_r <= frtf_pkg::COUNT_RST;
    end else if (low_power) begin
      capture_reg_b_r <= frtf_pkg::COUNT_RST;
      capture_reg_d_r <= frtf_pkg::COUNT_RST;
    end else begin
      if (cap_hit[2]) begin
        capture_reg_b_r <= free_running_counter_r;
        if (timer_control_r[frtf_pkg::CT_BUF_B]) begin
          capture_reg_d_r <= capture_reg_b_r;
        end
      end
      // Input D loads capture D only outside buffer mode B.
      if (cap_hit[0] && !timer_control_r[frtf_pkg::CT_BUF_B]) begin
        capture_reg_d_r <= free_running_counter_r;
      end
    end
  end

  // Hardware set sources; bit 0 is the clear-on-match control, not a flag.
  always_comb begin
    flag_set = 8'h00;
    flag_set[frtf_pkg::ST_CAP_A -: 4] = cap_hit;
    // Flag D sets on every valid edge, buffered or not.
    flag_set[frtf_pkg::ST_CAP_D] = cap_hit[0];
    flag_set[frtf_pkg::ST_CMP_A] = match_a;
    flag_set[frtf_pkg::ST_CMP_B] = match_b;
    flag_set[frtf_pkg::ST_OVF] = wrap;
  end

  // A 0 written to a flag clears it only if it was read as 1 before.
  assign flag_clr = (wr_acc && paddr == frtf_pkg::ADDR_STATUS) ?
                    (~pwdata[7:0] & read_seen_r & frtf_pkg::FLAG_MASK) : 8'h00;

  // Remember which flags a status read returned as 1; a write consumes it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_seen_r <= 8'h00;
    end else if (low_power) begin
      read_seen_r <= 8'h00;
    end else if (rd_acc && paddr == frtf_pkg::ADDR_STATUS) begin
      read_seen_r <= status_r & frtf_pkg::FLAG_MASK;
    end else if (wr_acc && paddr == frtf_pkg::ADDR_STATUS) begin
      read_seen_r <= 8'h00;
    end
  end

  // Status register: flags and the clear-on-match control bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= frtf_pkg::STATUS_RST;
    end else if (low_power) begin
      status_r <= frtf_pkg::STATUS_RST;
    end else begin
      // Writes never set a flag; a set beats a same-cycle clear.
      status_r[7:1] <= (status_r[7:1] & ~flag_clr[7:1]) | flag_set[7:1];
      if (wr_acc && paddr == frtf_pkg::ADDR_STATUS) begin
        status_r[frtf_pkg::ST_CLR_A] <= pwdata[frtf_pkg::ST_CLR_A];
      end
    end
  end

  // Each flag gated by its enable; flag D, like flag C in buffer mode A, works as an edge
  // interrupt when buffer mode B is on.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_r & irq_en_r & frtf_pkg::FLAG_MASK);
    end
  end

  // Address decode for the read mux and the error answer.
  always_comb begin
    addr_ok = 1'b1;
    prdata_nxt = 32'h0000_0000;
    unique case (paddr)
      frtf_pkg::ADDR_CONTROL: prdata_nxt[7:0] = timer_control_r;
      frtf_pkg::ADDR_STATUS: prdata_nxt[7:0] = status_r;
      frtf_pkg::ADDR_IRQ_EN: prdata_nxt[7:0] = irq_en_r;
      frtf_pkg::ADDR_COUNTER: prdata_nxt[15:0] = free_running_counter_r;
      frtf_pkg::ADDR_COMPARE_A: prdata_nxt[15:0] = compare_reg_a_r;
      frtf_pkg::ADDR_COMPARE_B: prdata_nxt[15:0] = compare_reg_b_r;
      frtf_pkg::ADDR_CAPTURE_A: prdata_nxt[15:0] = capture_reg_a_r;
      frtf_pkg::ADDR_CAPTURE_B: prdata_nxt[15:0] = capture_reg_b_r;
      frtf_pkg::ADDR_CAPTURE_C: prdata_nxt[15:0] = capture_reg_c_r;
      frtf_pkg::ADDR_CAPTURE_D: prdata_nxt[15:0] = capture_reg_d_r;
      frtf_pkg::ADDR_POWER: prdata_nxt = 32'h0000_0000;
      default: addr_ok = 1'b0;
    endcase
  end

  // APB answer: registered, so every access has exactly one wait state.
  // The pready flop rises in the first access cycle and is seen at the second edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok;
      prdata <= (psel & penable & ~pready & ~pwrite) ? prdata_nxt : 32'h0000_0000;
    end
  end
endmodule

// >>> verif/frtf_far_end.sv
`timescale 1ns/1ps
// Board logic at the far side: capture pins and the external count source.
module frtf_far_end (
  input wire logic pclk,
  output frtf_pkg::frtf_cap_pins_t cap_pins,
  output logic ext_clk
);
  initial begin
    cap_pins = '0;
    ext_clk = 1'b0;
  end
  // Pins are held at least two cycles, so a detector with a synchroniser sees them.
  task automatic pulse(input int idx, input int hold);
    @(posedge pclk);
    cap_pins[3 - idx] <= 1'b1;
    repeat (hold) @(posedge pclk);
    cap_pins[3 - idx] <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  // One rising edge of the count source; it stands low between uses.
  task automatic tick();
    @(posedge pclk);
    ext_clk <= 1'b1;
    repeat (2) @(posedge pclk);
    ext_clk <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
endmodule

// >>> verif/frtf_checker.sv
`timescale 1ns/1ps
// Watches the register bus and the interrupt of the timer.
module frtf_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire frtf_pkg::frtf_cap_pins_t cap_pins,
  input wire logic ext_clk,
  input wire logic irq
);
  logic [7:0] ctl_r;
  logic [7:0] en_r;
  logic [7:1] must_r;
  logic wr_edge;
  logic rd_done;
  logic en_any;
  logic pwr_off;
  assign wr_edge = psel && penable && pwrite && !pready;
  assign rd_done = psel && penable && !pwrite && pready;
  assign en_any = |en_r[7:1];
  assign pwr_off = wr_edge && paddr == frtf_pkg::ADDR_POWER && pwdata[0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadows of what software wrote; low-power entry wipes them as reset does.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= frtf_pkg::CONTROL_RST;
      en_r <= frtf_pkg::IRQ_EN_RST;
    end else if (pwr_off) begin
      ctl_r <= frtf_pkg::CONTROL_RST;
      en_r <= frtf_pkg::IRQ_EN_RST;
    end else if (wr_edge && paddr == frtf_pkg::ADDR_CONTROL) begin
      ctl_r <= pwdata[7:0];
    end else if (wr_edge && paddr == frtf_pkg::ADDR_IRQ_EN) begin
      en_r <= {pwdata[7:1], 1'b1};
    end
  end
  // A flag read as 1 may only vanish through a later status write of 0 or through low-power entry.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      must_r <= '0;
    end else if (pwr_off) begin
      must_r <= '0;
    end else if (wr_edge && paddr == frtf_pkg::ADDR_STATUS) begin
      must_r <= must_r & pwdata[7:1];
    end else if (rd_done && paddr == frtf_pkg::ADDR_STATUS) begin
      must_r <= must_r | prdata[7:1];
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_ready_wait: assert property (s_setup ##1 s_access |=> pready)
    else $error("Access not answered after one wait state.");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("Ready stood longer than one cycle.");
  a_err_unmapped: assert property (pready && paddr[1:0] == 2'h0 |->
    pslverr == (paddr > frtf_pkg::ADDR_POWER))
    else $error("Error response does not match the address map.");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("Read data shown outside an answer.");
  a_ctrl_readback: assert property (
    rd_done && paddr == frtf_pkg::ADDR_CONTROL |-> prdata == {24'h0, ctl_r})
    else $error("Control read differs from the value written.");
  a_irqen_readback: assert property (
    rd_done && paddr == frtf_pkg::ADDR_IRQ_EN |-> prdata == {24'h0, en_r})
    else $error("Interrupt enable read differs from the value written.");
  a_flag_sticky: assert property (
    rd_done && paddr == frtf_pkg::ADDR_STATUS |-> (prdata[7:1] & must_r) == must_r)
    else $error("Status flag cleared without read and zero write.");
  a_irq_masked: assert property (irq |-> $past(en_any) || $past(en_any, 2))
    else $error("Interrupt raised with every enable off.");
  a_irq_quiet: assert property ($rose(presetn) |-> !irq [*2])
    else $error("Interrupt high just after reset.");
endmodule
bind frtf_timer frtf_checker u_frtf_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cap_pins(cap_pins), .ext_clk(ext_clk), .irq(irq));

// >>> verif/frtf_timer_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the timer registers, flags and interrupt.
module frtf_timer_tb;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  frtf_pkg::frtf_cap_pins_t cap_pins;
  logic ext_clk;
  logic irq;
  int fail_count;
  int checks;
  logic [32:0] exp_q[$];
  logic [15:0] v1;
  logic [15:0] v2;
  frtf_timer u_frtf_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cap_pins(cap_pins), .ext_clk(ext_clk), .irq(irq));
  frtf_far_end u_frtf_far_end (.pclk(pclk), .cap_pins(cap_pins), .ext_clk(ext_clk));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // One transfer; the expected error bit and read data go to the queue first.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask
  // Holds input D high long enough to read the status while it is high.
  task automatic edge_case(input logic [7:0] c, input logic [31:0] mid);
    wr(frtf_pkg::ADDR_CONTROL, {24'h0, c});
    fork
      u_frtf_far_end.pulse(3, 20);
      begin
        repeat (6) @(posedge pclk);
        rd(frtf_pkg::ADDR_STATUS, mid);
      end
    join
    rd(frtf_pkg::ADDR_STATUS, 32'h10);
    wr(frtf_pkg::ADDR_STATUS, 32'h0);
    rd(frtf_pkg::ADDR_CAPTURE_D, {16'h0, v1});
  endtask
  // Every bus answer is compared with the oldest queued expectation.
  always @(posedge pclk) begin
    if (presetn && psel && penable && pready === 1'b1) begin
      chk({pslverr, prdata}, exp_q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    wrap_up();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    fail_count = 0;
    checks = 0;
    void'($urandom(32'h042f48c1));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(frtf_pkg::ADDR_CONTROL, 32'h0);
    rd(frtf_pkg::ADDR_STATUS, 32'h0);
    rd(frtf_pkg::ADDR_IRQ_EN, 32'h1);
    repeat (3) begin
      v1 = 16'($urandom());
      wr(frtf_pkg::ADDR_CONTROL, {v1, v1});
      rd(frtf_pkg::ADDR_CONTROL, {24'h0, v1[7:0]});
    end
    apb(1'b1, 8'h40, 32'h5, {1'b1, 32'h0});
    apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
    $display("test registers done");
    v1 = 16'($urandom_range(32'h7fff, 32'h1000));
    v2 = 16'($urandom_range(32'hefff, 32'h8000));
    // The random control value may leave an internal clock running; select the idle
    // external source first so the captured count is the value written.
    wr(frtf_pkg::ADDR_CONTROL, 32'h03);
    wr(frtf_pkg::ADDR_COUNTER, {16'h0, v1});
    edge_case(8'h13, 32'h10);
    edge_case(8'h03, 32'h00);
    u_frtf_far_end.pulse(3, 2);
    wr(frtf_pkg::ADDR_STATUS, 32'h0);
    rd(frtf_pkg::ADDR_STATUS, 32'h10);
    wr(frtf_pkg::ADDR_STATUS, 32'hfe);
    wr(frtf_pkg::ADDR_STATUS, 32'h0);
    rd(frtf_pkg::ADDR_STATUS, 32'h10);
    wr(frtf_pkg::ADDR_STATUS, 32'h0);
    rd(frtf_pkg::ADDR_STATUS, 32'h0);
    $display("test capture done");
    wr(frtf_pkg::ADDR_CONTROL, 32'h57);
    wr(frtf_pkg::ADDR_COUNTER, {16'h0, v2});
    u_frtf_far_end.pulse(1, 2);
    wr(frtf_pkg::ADDR_COUNTER, {16'h0, v1});
    u_frtf_far_end.pulse(1, 2);
    rd(frtf_pkg::ADDR_CAPTURE_B, {16'h0, v1});
    rd(frtf_pkg::ADDR_CAPTURE_D, {16'h0, v2});
    chk({32'h0, irq}, 33'h0);
    wr(frtf_pkg::ADDR_IRQ_EN, 32'h10);
    u_frtf_far_end.pulse(3, 2);
    rd(frtf_pkg::ADDR_CAPTURE_D, {16'h0, v2});
    chk({32'h0, irq}, 33'h1);
    wr(frtf_pkg::ADDR_IRQ_EN, 32'h0);
    repeat (2) @(posedge pclk);
    chk({32'h0, irq}, 33'h0);
    rd(frtf_pkg::ADDR_STATUS, 32'h50);
    wr(frtf_pkg::ADDR_STATUS, 32'h0);
    $display("test buffer done");
    wr(frtf_pkg::ADDR_CONTROL, 32'h03);
    wr(frtf_pkg::ADDR_COMPARE_A, 32'h0100);
    wr(frtf_pkg::ADDR_COMPARE_B, 32'h0200);
    wr(frtf_pkg::ADDR_COUNTER, 32'h00ff);
    u_frtf_far_end.tick();
    rd(frtf_pkg::ADDR_COUNTER, 32'h0100);
    rd(frtf_pkg::ADDR_STATUS, 32'h08);
    wr(frtf_pkg::ADDR_COUNTER, 32'h01ff);
    u_frtf_far_end.tick();
    rd(frtf_pkg::ADDR_STATUS, 32'h0c);
    wr(frtf_pkg::ADDR_COUNTER, 32'hffff);
    u_frtf_far_end.tick();
    rd(frtf_pkg::ADDR_COUNTER, 32'h0);
    rd(frtf_pkg::ADDR_STATUS, 32'h0e);
    wr(frtf_pkg::ADDR_STATUS, 32'h01);
    wr(frtf_pkg::ADDR_COUNTER, 32'h00ff);
    u_frtf_far_end.tick();
    rd(frtf_pkg::ADDR_COUNTER, 32'h0);
    rd(frtf_pkg::ADDR_STATUS, 32'h09);
    wr(frtf_pkg::ADDR_POWER, 32'h1);
    rd(frtf_pkg::ADDR_CONTROL, 32'h0);
    rd(frtf_pkg::ADDR_STATUS, 32'h0);
    $display("test compare done");
    wrap_up();
  end
endmodule
